/* File: src/psc_cfg.svh */
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PSC_CLK_HZ 125000000
`define PSC_WARN_TIME_S 10
`define PSC_WARN_CYCLES (`PSC_WARN_TIME_S * `PSC_CLK_HZ)

// ----------------------------------------
// Serial target addressing and commands
// ----------------------------------------
`define PSC_MCU_NIBBLE 4'hb
`define PSC_EEP_NIBBLE 4'ha
`define PSC_CMD_OPERATION 8'h01
`define PSC_OP_ON_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSC_SYNC_RST 1'b0
`define PSC_RELEASED 1'b1
`define PSC_PULLED 1'b0

`endif

/* File: src/psc_pkg.sv */
package psc_pkg;

    // Serial target sequencer, one-hot
    typedef enum logic [6:0] {
        PSC_I2C_IDLE  = 7'h01,
        PSC_I2C_ADDR  = 7'h02,
        PSC_I2C_ACK_A = 7'h04,
        PSC_I2C_WRITE = 7'h08,
        PSC_I2C_ACK_W = 7'h10,
        PSC_I2C_READ  = 7'h20,
        PSC_I2C_ACK_R = 7'h40
    } psc_i2c_state_t;

    // Thermal supervisor, one-hot
    typedef enum logic [2:0] {
        PSC_TH_NORMAL = 3'h1,
        PSC_TH_WARN   = 3'h2,
        PSC_TH_SHUT   = 3'h4
    } psc_therm_state_t;

endpackage

/* File: src/psc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psc_cfg.svh"

module psc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    generate
        if (W < 1) begin : g_bad
            $error("psc_sync needs W of at least one");
        end
    endgenerate

    // Two stages; only the second stage is read outside
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {W{`PSC_SYNC_RST}};
            sync_reg <= {W{`PSC_SYNC_RST}};
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign level_out = sync_reg;

endmodule
`default_nettype wire

/* File: src/psc_thermal.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psc_cfg.svh"

module psc_thermal #(
    parameter int unsigned WARN_CYCLES = `PSC_WARN_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Synchronised over-temperature sense
    input wire logic over_temp,
    // Warning line request and shutdown
    output logic warn_reg,
    output logic shut_reg
);

    localparam int unsigned CW = (WARN_CYCLES > 1) ? $clog2(WARN_CYCLES) : 1;

    psc_pkg::psc_therm_state_t st_reg;
    psc_pkg::psc_therm_state_t st_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic expired;

    generate
        if (WARN_CYCLES < 1) begin : g_bad
            $error("psc_thermal needs WARN_CYCLES of at least one");
        end
    endgenerate

    assign expired = (cnt_reg == CW'(WARN_CYCLES - 1));

    always_comb begin
        st_next = st_reg;
        cnt_next = '0;
        case (st_reg)
            psc_pkg::PSC_TH_NORMAL: begin
                if (over_temp) begin
                    st_next = psc_pkg::PSC_TH_WARN;
                end
            end
            psc_pkg::PSC_TH_WARN: begin
                if (!over_temp) begin
                    st_next = psc_pkg::PSC_TH_NORMAL;
                end else if (expired) begin
                    st_next = psc_pkg::PSC_TH_SHUT;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            psc_pkg::PSC_TH_SHUT: begin
                if (!over_temp) begin
                    st_next = psc_pkg::PSC_TH_NORMAL;
                end
            end
            default: begin
                st_next = psc_pkg::PSC_TH_NORMAL;
            end
        endcase
    end

    // Outputs follow the next state so they stay flop-driven
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= psc_pkg::PSC_TH_NORMAL;
            cnt_reg <= '0;
            warn_reg <= 1'b0;
            shut_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            warn_reg <= (st_next != psc_pkg::PSC_TH_NORMAL);
            shut_reg <= (st_next == psc_pkg::PSC_TH_SHUT);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence warn_expiring;
        st_reg == psc_pkg::PSC_TH_WARN && expired && over_temp;
    endsequence

    warn_then_shut_a: assert property (warn_expiring |=> shut_reg && warn_reg)
        else $error("shutdown did not follow warning period");
    warn_no_early_a: assert property (st_reg == psc_pkg::PSC_TH_WARN && !expired |-> !shut_reg)
        else $error("shutdown before warning period ended");
    restart_release_a: assert property (shut_reg && !over_temp |=> !shut_reg && !warn_reg)
        else $error("no restart after temperature recovered");

endmodule
`default_nettype wire

/* File: src/psc_status_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psc_cfg.svh"


module psc_status_ctrl #(
    parameter int unsigned WARN_CYCLES = `PSC_WARN_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control pins
    input wire logic remote_on_pin,
    input wire logic enable_pin,
    input wire logic write_lock_pin,
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    // Power-train sense
    input wire logic input_in_range,
    input wire logic output_present,
    input wire logic over_temp_det,
    input wire logic over_voltage_trip,
    input wire logic over_current_trip,
    // Serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // EEPROM side
    input wire logic [7:0] eep_rd_data,
    output logic eep_wr_stb,
    output logic eep_wr_first,
    output logic [7:0] eep_wr_data,
    // Power stage and status lines
    output logic main_out_en,
    output logic input_good_oe_n,
    output logic output_good_oe_n,
    output logic temp_warn_oe_n,
    output logic fault_oe_n,
    output logic unit_inserted_flag_oe_n,
    output logic alert_oe_n
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic remote_on_s;
    logic enable_s;
    logic wl_s;
    logic [2:0] sel_s;
    logic in_range_s;
    logic out_present_s;
    logic ot_s;
    logic ovp_s;
    logic ocp_s;
    logic scl_s;
    logic sda_s;

    psc_sync #(.W(13)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_in({remote_on_pin, enable_pin, write_lock_pin, addr_select_bit2, addr_select_bit1,
            addr_select_bit0, input_in_range, output_present, over_temp_det, over_voltage_trip,
            over_current_trip, scl_in, sda_in}),
        .level_out({remote_on_s, enable_s, wl_s, sel_s, in_range_s, out_present_s, ot_s, ovp_s,
            ocp_s, scl_s, sda_s})
    );

    // ----------------------------------------
    // Thermal supervisor
    // ----------------------------------------
    logic therm_warn;
    logic therm_shut;

    psc_thermal #(.WARN_CYCLES(WARN_CYCLES)) u_thermal (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .over_temp(ot_s),
        .warn_reg(therm_warn),
        .shut_reg(therm_shut)
    );

    // ----------------------------------------
    // Serial bus decode
    // ----------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_done;
    logic hit_mcu;
    logic hit_eep;
    logic wr_accept;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;
    logic alert_clr;
    logic fault_now;
    logic scl_d_reg;
    logic sda_d_reg;
    psc_pkg::psc_i2c_state_t st_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic [7:0] tx_reg;
    logic [7:0] cmd_reg;
    logic is_mcu_reg;
    logic first_reg;
    logic fw_off_reg;

    // clock edges come from host clock; start and stop come from data edges while clock is high
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign byte_done = scl_fall & (bit_reg == 4'h8);

    // strapped addresses, open select pins read high
    assign hit_mcu = (sh_reg[7:1] == {`PSC_MCU_NIBBLE, sel_s});
    assign hit_eep = (sh_reg[7:1] == {`PSC_EEP_NIBBLE, sel_s});
    // EEPROM bytes accepted only while lock is driven low
    assign wr_accept = is_mcu_reg | ~wl_s;
    assign status_byte = {3'h0, fw_off_reg, therm_warn, ~in_range_s, ~out_present_s, fault_now};
    // data only leaves on a host read
    assign rd_byte = is_mcu_reg ? status_byte : eep_rd_data;
    assign alert_clr = (st_reg == psc_pkg::PSC_I2C_ADDR) & byte_done & hit_mcu & sh_reg[0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Byte sequencer; start and stop override any state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= psc_pkg::PSC_I2C_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            cmd_reg <= 8'h00;
            is_mcu_reg <= 1'b0;
            first_reg <= 1'b0;
            fw_off_reg <= 1'b0;
            sda_oe_n <= `PSC_RELEASED;
            eep_wr_stb <= 1'b0;
            eep_wr_first <= 1'b0;
            eep_wr_data <= 8'h00;
        end else begin
            eep_wr_stb <= 1'b0;
            if (bus_start) begin
                st_reg <= psc_pkg::PSC_I2C_ADDR;
                bit_reg <= 4'h0;
                sda_oe_n <= `PSC_RELEASED;
            end else if (bus_stop) begin
                st_reg <= psc_pkg::PSC_I2C_IDLE;
                sda_oe_n <= `PSC_RELEASED;
            end else begin
                case (st_reg)
                    psc_pkg::PSC_I2C_ADDR, psc_pkg::PSC_I2C_WRITE: begin
                        if (scl_rise && bit_reg != 4'h8) begin
                            sh_reg <= {sh_reg[6:0], sda_s};
                            bit_reg <= bit_reg + 4'h1;
                        end else if (byte_done && st_reg == psc_pkg::PSC_I2C_ADDR) begin
                            bit_reg <= 4'h0;
                            if (hit_mcu || hit_eep) begin
                                st_reg <= psc_pkg::PSC_I2C_ACK_A;
                                sda_oe_n <= `PSC_PULLED;
                                is_mcu_reg <= hit_mcu;
                                first_reg <= 1'b1;
                            end else begin
                                st_reg <= psc_pkg::PSC_I2C_IDLE;
                            end
                        end else if (byte_done) begin
                            bit_reg <= 4'h0;
                            first_reg <= 1'b0;
                            // locked EEPROM byte is not acknowledged
                            if (wr_accept) begin
                                st_reg <= psc_pkg::PSC_I2C_ACK_W;
                                sda_oe_n <= `PSC_PULLED;
                                eep_wr_stb <= ~is_mcu_reg;
                                eep_wr_first <= first_reg;
                                eep_wr_data <= sh_reg;
                            end else begin
                                st_reg <= psc_pkg::PSC_I2C_IDLE;
                            end
                            if (is_mcu_reg && first_reg) begin
                                cmd_reg <= sh_reg;
                            end else if (is_mcu_reg && cmd_reg == `PSC_CMD_OPERATION) begin
                                fw_off_reg <= ~sh_reg[`PSC_OP_ON_BIT];
                            end
                        end
                    end
                    psc_pkg::PSC_I2C_ACK_A: begin
                        if (scl_fall && sh_reg[0]) begin
                            st_reg <= psc_pkg::PSC_I2C_READ;
                            tx_reg <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            bit_reg <= 4'h1;
                        end else if (scl_fall) begin
                            st_reg <= psc_pkg::PSC_I2C_WRITE;
                            sda_oe_n <= `PSC_RELEASED;
                        end
                    end
                    psc_pkg::PSC_I2C_ACK_W: begin
                        if (scl_fall) begin
                            st_reg <= psc_pkg::PSC_I2C_WRITE;
                            sda_oe_n <= `PSC_RELEASED;
                        end
                    end
                    psc_pkg::PSC_I2C_READ: begin
                        // read bits change only while clock is low
                        if (byte_done) begin
                            st_reg <= psc_pkg::PSC_I2C_ACK_R;
                            sda_oe_n <= `PSC_RELEASED;
                            bit_reg <= 4'h0;
                        end else if (scl_fall) begin
                            sda_oe_n <= tx_reg[6];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end
                    psc_pkg::PSC_I2C_ACK_R: begin
                        if (scl_rise && sda_s) begin
                            st_reg <= psc_pkg::PSC_I2C_IDLE;
                        end else if (scl_fall) begin
                            st_reg <= psc_pkg::PSC_I2C_READ;
                            tx_reg <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            bit_reg <= 4'h1;
                        end
                    end
                    default: begin
                        st_reg <= psc_pkg::PSC_I2C_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Output control and status lines
    // ----------------------------------------
    logic out_on_next;
    logic [3:0] stat_now;
    logic [3:0] stat_d_reg;
    logic alert_reg;
    logic alert_next;
    logic pres_reg;
    logic sda_o_reg;

    assign out_on_next = remote_on_s & ~enable_s & ~fw_off_reg & ~therm_shut & ~ovp_s & ~ocp_s;
    // thermal, over-voltage or over-current shutdown, or missing input or output
    assign fault_now = therm_shut | ovp_s | ocp_s | ~in_range_s | ~out_present_s;
    assign stat_now = {in_range_s, out_present_s, therm_warn, fault_now};
    // a change in input, output, warning or fault status raises the alert; set beats clear
    assign alert_next = (stat_now != stat_d_reg) | (alert_reg & ~alert_clr);

    // Open-drain lines: low enable means the line is pulled low
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            main_out_en <= 1'b0;
            input_good_oe_n <= `PSC_PULLED;
            output_good_oe_n <= `PSC_PULLED;
            temp_warn_oe_n <= `PSC_RELEASED;
            fault_oe_n <= `PSC_PULLED;
            alert_oe_n <= `PSC_RELEASED;
            alert_reg <= 1'b0;
            stat_d_reg <= 4'h1;
            pres_reg <= `PSC_PULLED;
            sda_o_reg <= 1'b0;
        end else begin
            main_out_en <= out_on_next;
            input_good_oe_n <= in_range_s;
            output_good_oe_n <= out_present_s;
            temp_warn_oe_n <= ~therm_warn;
            fault_oe_n <= ~fault_now;
            stat_d_reg <= stat_now;
            alert_reg <= alert_next;
            alert_oe_n <= ~alert_next;
            pres_reg <= `PSC_PULLED;
            sda_o_reg <= 1'b0;
        end
    end

    assign unit_inserted_flag_oe_n = pres_reg;
    assign sda_out = sda_o_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence addr_byte_end;
        st_reg == psc_pkg::PSC_I2C_ADDR && byte_done && !bus_start && !bus_stop;
    endsequence

    remote_off_a: assert property (!remote_on_s |=> !main_out_en)
        else $error("output on while remote switch low");
    fw_off_a: assert property (fw_off_reg |=> !main_out_en)
        else $error("output on after firmware off");
    hotplug_off_a: assert property (enable_s |=> !main_out_en)
        else $error("output on with hot-plug pin open");
    all_on_a: assert property (out_on_next |=> main_out_en)
        else $error("output stayed off with all conditions met");
    eep_lock_a: assert property (eep_wr_stb |-> !$past(wl_s))
        else $error("EEPROM write under lock");
    input_good_a: assert property (in_range_s |=> input_good_oe_n)
        else $error("input-good pulled while input in range");
    output_good_a: assert property (!out_present_s |=> !output_good_oe_n)
        else $error("output-good released without output");
    fault_trip_a: assert property ((ovp_s || ocp_s) |=> !fault_oe_n)
        else $error("fault line not asserted on trip");
    presence_tied_a: assert property (!unit_inserted_flag_oe_n)
        else $error("presence pin released");
    alert_change_a: assert property ($changed(stat_now) |=> !alert_oe_n)
        else $error("alert not raised on status change");
    addr_ack_a: assert property (addr_byte_end ##0 (hit_mcu || hit_eep) |=> !sda_oe_n ##1 st_reg == psc_pkg::PSC_I2C_ACK_A)
        else $error("own address not acknowledged");
    addr_foreign_a: assert property (addr_byte_end ##0 !(hit_mcu || hit_eep) |=> sda_oe_n && st_reg == psc_pkg::PSC_I2C_IDLE)
        else $error("foreign address acknowledged");

endmodule
`default_nettype wire

/* File: tb/psc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial bus host model
// ----------------------------------------
module psc_host (
    // Clock
    input wire logic clk_sys,
    // Bus wires, high on sda means released
    input wire logic sda_w,
    output logic scl,
    output logic sda
);
    // Idle with both lines released
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Five-cycle phases stay above the three-cycle sync floor
    task automatic hw();
        repeat (5) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(output logic v);
        hw();
        scl = 1'b1;
        hw();
        v = sda_w;
        scl = 1'b0;
    endtask
    task automatic start();
        sda = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sda = 1'b0;
        hw();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sda = 1'b1;
        hw();
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            pulse(v);
        end
        sda = 1'b1;
        pulse(v);
        ack = ~v;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic v;
        sda = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            pulse(v);
            b[i] = v;
        end
        sda = last;
        pulse(v);
        sda = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb/psc_status_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module psc_status_ctrl_test;
    localparam int unsigned WARN = 20;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic remote_on_pin = 1'b1, enable_pin = 1'b0, write_lock_pin = 1'b1;
    logic over_temp_det = 1'b0, over_voltage_trip = 1'b0, over_current_trip = 1'b0;
    logic input_in_range = 1'b1, output_present = 1'b1;
    logic [2:0] sel = 3'h5;
    logic [7:0] eep_rd_data = 8'h00;
    wire scl_w, host_sda, sda_out, sda_oe_n, sda_w, eep_wr_stb, eep_wr_first;
    wire main_out_en, input_good_oe_n, output_good_oe_n, temp_warn_oe_n;
    wire fault_oe_n, unit_inserted_flag_oe_n, alert_oe_n;
    wire [7:0] eep_wr_data;
    int failures = 0, checked = 0, cycles = 0, stbs = 0;
    assign sda_w = host_sda & (sda_oe_n | sda_out);
    always #4 clk_sys = ~clk_sys;
    // straps 101 tied by the system
    psc_status_ctrl #(.WARN_CYCLES(WARN)) psc_status_ctrl_inst (.clk_sys, .nrst,
        .remote_on_pin, .enable_pin, .write_lock_pin, .addr_select_bit2(sel[2]),
        .addr_select_bit1(sel[1]), .addr_select_bit0(sel[0]), .input_in_range,
        .output_present, .over_temp_det, .over_voltage_trip, .over_current_trip,
        .scl_in(scl_w), .sda_in(sda_w), .sda_out, .sda_oe_n, .eep_rd_data, .eep_wr_stb,
        .eep_wr_first, .eep_wr_data, .main_out_en, .input_good_oe_n, .output_good_oe_n,
        .temp_warn_oe_n, .fault_oe_n, .unit_inserted_flag_oe_n, .alert_oe_n);
    psc_host psc_host_inst (.clk_sys, .sda_w, .scl(scl_w), .sda(host_sda));
    // Write strobes counted and hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (eep_wr_stb === 1'b1)
            stbs++;
        if (cycles == LIMIT) begin
            failures++;
            conclude();
        end
    end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Settle past sync and output flops
    task automatic st();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic send(input logic [7:0] a, c, d, input int n, output logic [2:0] k);
        logic [7:0] b [3];
        b = '{a, c, d};
        k = 3'h0;
        psc_host_inst.start();
        for (int i = 0; i < n; i++)
            psc_host_inst.wr_byte(b[i], k[i]);
        psc_host_inst.stop();
    endtask
    task automatic t_pins();
        st();
        check("present", 8'(unit_inserted_flag_oe_n), 8'h00);
        check("main on", 8'(main_out_en), 8'h01);
        check("in good", 8'(input_good_oe_n), 8'h01);
        check("out good", 8'(output_good_oe_n), 8'h01);
        check("fault", 8'(fault_oe_n), 8'h01);
        check("sda idle", 8'(sda_oe_n), 8'h01);
        remote_on_pin = 1'b0;
        st();
        check("remote off", 8'(main_out_en), 8'h00);
        remote_on_pin = 1'b1;
        enable_pin = 1'b1;
        st();
        check("unplug", 8'(main_out_en), 8'h00);
        enable_pin = 1'b0;
        input_in_range = 1'b0;
        st();
        check("in bad", 8'(input_good_oe_n), 8'h00);
        check("fault in", 8'(fault_oe_n), 8'h00);
        input_in_range = 1'b1;
        output_present = 1'b0;
        st();
        check("out bad", 8'(output_good_oe_n), 8'h00);
        check("fault out", 8'(fault_oe_n), 8'h00);
        output_present = 1'b1;
        over_voltage_trip = 1'b1;
        st();
        check("fault ov", 8'(fault_oe_n), 8'h00);
        over_voltage_trip = 1'b0;
        over_current_trip = 1'b1;
        st();
        check("fault oc", 8'(fault_oe_n), 8'h00);
        over_current_trip = 1'b0;
        st();
        check("fault clear", 8'(fault_oe_n), 8'h01);
    endtask
    task automatic t_therm();
        over_temp_det = 1'b1;
        st();
        check("warn", 8'(temp_warn_oe_n), 8'h00);
        check("still on", 8'(main_out_en), 8'h01);
        repeat (WARN) @(posedge clk_sys);
        st();
        check("shut", 8'(main_out_en), 8'h00);
        check("fault ot", 8'(fault_oe_n), 8'h00);
        over_temp_det = 1'b0;
        st();
        check("warn off", 8'(temp_warn_oe_n), 8'h01);
        check("restart", 8'(main_out_en), 8'h01);
    endtask
    task automatic t_addr();
        logic [7:0] a [4] = '{8'hba, 8'haa, 8'hb8, 8'h9a};
        logic [2:0] e [4] = '{3'h1, 3'h1, 3'h0, 3'h0};
        logic [2:0] k;
        for (int i = 0; i < 4; i++) begin
            send(a[i], 8'h00, 8'h00, 1, k);
            check("addr ack", 8'(k), 8'(e[i]));
        end
        sel = 3'h2;
        st();
        send(8'hb4, 8'h00, 8'h00, 1, k);
        check("strap ack", 8'(k), 8'h01);
        send(8'hba, 8'h00, 8'h00, 1, k);
        check("strap old", 8'(k), 8'h00);
        sel = 3'h5;
        st();
    endtask
    // firmware off, status read, alert clear
    task automatic t_fw();
        logic [2:0] k;
        logic ak;
        logic [7:0] b;
        send(8'hba, 8'h01, 8'h00, 3, k);
        check("cmd ack", 8'(k), 8'h07);
        st();
        check("fw off", 8'(main_out_en), 8'h00);
        check("alert set", 8'(alert_oe_n), 8'h00);
        psc_host_inst.start();
        psc_host_inst.wr_byte(8'hbb, ak);
        psc_host_inst.rd_byte(1'b1, b);
        psc_host_inst.stop();
        check("rd ack", 8'(ak), 8'h01);
        check("status", b, 8'h10);
        st();
        check("alert clr", 8'(alert_oe_n), 8'h01);
        input_in_range = 1'b0;
        st();
        check("alert again", 8'(alert_oe_n), 8'h00);
        input_in_range = 1'b1;
        send(8'hba, 8'h01, 8'h80, 3, k);
        st();
        check("fw on", 8'(main_out_en), 8'h01);
    endtask
    task automatic t_eep();
        logic [2:0] k;
        logic ak;
        logic [7:0] b;
        send(8'haa, 8'h3c, 8'h00, 2, k);
        check("lock ack", 8'(k), 8'h01);
        check("lock stb", 8'(stbs), 8'h00);
        write_lock_pin = 1'b0;
        st();
        send(8'haa, 8'hc3, 8'h00, 2, k);
        check("wr ack", 8'(k), 8'h03);
        check("wr stb", 8'(stbs), 8'h01);
        check("wr data", eep_wr_data, 8'hc3);
        check("wr first", 8'(eep_wr_first), 8'h01);
        eep_rd_data = 8'h5a;
        psc_host_inst.start();
        psc_host_inst.wr_byte(8'hab, ak);
        psc_host_inst.rd_byte(1'b1, b);
        psc_host_inst.stop();
        check("eep rd ack", 8'(ak), 8'h01);
        check("eep rd data", b, 8'h5a);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        t_pins();
        t_therm();
        t_addr();
        t_fw();
        t_eep();
        conclude();
    end
endmodule
`default_nettype wire
